/* spm_burst.sv */
`timescale 1ns/1ps
module spm_burst
  import spm_pkg::*;
#(
  parameter int BURST_W = spm_pkg::SPM_BURST_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Control
  input wire logic start,
  input wire logic stop,
  input wire logic hold,
  input wire logic [BURST_W-1:0] length,
  // Status
  output logic busy,
  output logic last
);
  logic [BURST_W-1:0] count_reg;
  logic [BURST_W-1:0] count_next;

  initial begin
    if (BURST_W < 2) $error("spm_burst: BURST_W too small");
  end

  // Counts remaining beats; hold freezes the count while suspended
  always_comb begin
    count_next = count_reg;
    if (hold) begin
      count_next = count_reg;
    end else if (start) begin
      count_next = length;
    end else if (stop) begin
      count_next = '0;
    end else if (count_reg != '0) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= SPM_CNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  assign busy = (count_reg != '0);
  assign last = (count_reg == {{(BURST_W-1){1'b0}}, 1'b1}) && !hold;
endmodule

/* spm_cmd_if.sv */
`timescale 1ns/1ps
// Carries the decoded command from decoder to state machine
interface spm_cmd_if;
  import spm_pkg::*;
  spm_cmd_t cmd;
  logic gate_now;
  logic gate_prev;
  logic [spm_pkg::SPM_BANK_W-1:0] bank;
  logic pre_flag;
  modport dec (output cmd, gate_now, gate_prev, bank, pre_flag);
  modport fsm (input cmd, gate_now, gate_prev, bank, pre_flag);
endinterface

/* spm_ctrl_model.sv */
`timescale 1ns/1ps
// Memory controller side; pins change only after a falling edge
module spm_ctrl_model #(
  parameter int EXIT_GAP = 2
) (
  // Clock
  input wire logic mclk,
  // Command pins
  output logic chip_select_n,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic write_enable_n,
  output logic clock_gate_in,
  output logic [1:0] bank_select,
  output logic precharge_flag_addr
);
  // Idle pins: deselected with the gate high
  initial begin
    {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'hf;
    clock_gate_in = 1'b1;
    bank_select = 2'h0;
    precharge_flag_addr = 1'b0;
  end

  // One command per cycle, held for the whole cycle
  task automatic send(input logic [3:0] c, input logic g, input logic [1:0] b, input logic f);
    @(negedge mclk);
    {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = c;
    clock_gate_in = g;
    bank_select = b;
    precharge_flag_addr = f;
  endtask

  // Waking edge carries a no-op, then a quiet gap before real commands
  task automatic wake();
    send(4'h7, 1'b1, 2'h0, 1'b0);
    repeat (EXIT_GAP) send(4'hf, 1'b1, 2'h0, 1'b0);
  endtask
endmodule

/* spm_decode.sv */
`timescale 1ns/1ps
module spm_decode
  import spm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Command pins
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_enable_n,
  input wire logic clock_gate_in,
  input wire logic [spm_pkg::SPM_BANK_W-1:0] bank_select,
  input wire logic precharge_flag_addr,
  // Decoded command
  spm_cmd_if.dec cmd_o
);
  logic gate_prev_reg;
  logic [2:0] strobes;
  spm_cmd_t pin_cmd;

  // Previous gate level, for qualifying each command
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gate_prev_reg <= 1'b1;
    end else begin
      gate_prev_reg <= clock_gate_in;
    end
  end

  // Truth table of the strobes; deselect ignores all strobes
  assign strobes = {row_strobe_n, column_strobe_n, write_enable_n};
  always_comb begin
    pin_cmd = SPM_CMD_NOP;
    if (chip_select_n) begin
      pin_cmd = SPM_CMD_DESEL;
    end else begin
      case (strobes)
        3'b111: pin_cmd = SPM_CMD_NOP;
        3'b011: pin_cmd = SPM_CMD_ACT;
        3'b010: pin_cmd = SPM_CMD_PRE;
        3'b100: pin_cmd = SPM_CMD_WR;
        3'b101: pin_cmd = SPM_CMD_RD;
        3'b000: pin_cmd = SPM_CMD_MRS;
        3'b110: pin_cmd = SPM_CMD_BST;
        default: pin_cmd = clock_gate_in ? SPM_CMD_AREF : SPM_CMD_SREF;
      endcase
    end
  end

  assign cmd_o.cmd = pin_cmd;
  assign cmd_o.gate_now = clock_gate_in;
  assign cmd_o.gate_prev = gate_prev_reg;
  assign cmd_o.bank = bank_select;
  assign cmd_o.pre_flag = precharge_flag_addr;
endmodule

/* spm_pkg.sv */
package spm_pkg;
  localparam int SPM_BANKS = 4;
  localparam int SPM_BANK_W = 2;
  localparam int SPM_ADDR_W = 12;
  localparam int SPM_PRE_BIT = 10;
  localparam int SPM_MASK_W = 2;
  localparam int SPM_BURST_W = 9;
  // Full page burst length code and count
  localparam logic [SPM_BURST_W-1:0] SPM_FULL_PAGE = 9'h100;
  localparam logic [SPM_BURST_W-1:0] SPM_BURST_RST = 9'h004;
  localparam logic [SPM_BANKS-1:0] SPM_BANKS_RST = 4'h0;
  localparam logic [SPM_BURST_W-1:0] SPM_CNT_RST = 9'h000;

  // Decoded commands
  typedef enum logic [3:0] {
    SPM_CMD_NOP = 4'h0,
    SPM_CMD_DESEL = 4'h1,
    SPM_CMD_ACT = 4'h2,
    SPM_CMD_PRE = 4'h3,
    SPM_CMD_WR = 4'h4,
    SPM_CMD_RD = 4'h5,
    SPM_CMD_MRS = 4'h6,
    SPM_CMD_BST = 4'h7,
    SPM_CMD_AREF = 4'h8,
    SPM_CMD_SREF = 4'h9
  } spm_cmd_t;

  // Power states
  typedef enum logic [2:0] {
    SPM_ST_IDLE = 3'h0,
    SPM_ST_ACTIVE = 3'h1,
    SPM_ST_SREF = 3'h2,
    SPM_ST_PDOWN = 3'h3,
    SPM_ST_SUSP = 3'h4
  } spm_state_t;
endpackage

/* spm_power_ctrl.sv */
`timescale 1ns/1ps
module spm_power_ctrl
  import spm_pkg::*;
#(
  parameter int BANKS = spm_pkg::SPM_BANKS,
  parameter int MASK_W = spm_pkg::SPM_MASK_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Command pins
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_enable_n,
  input wire logic clock_gate_in,
  input wire logic [spm_pkg::SPM_BANK_W-1:0] bank_select,
  input wire logic precharge_flag_addr,
  input wire logic [MASK_W-1:0] byte_mask,
  // Burst length in beats, set by mode register logic outside
  input wire logic [spm_pkg::SPM_BURST_W-1:0] burst_length,
  // Status
  output spm_pkg::spm_state_t power_state,
  output logic [BANKS-1:0] bank_open,
  output logic internal_clk_en,
  output logic burst_busy,
  output logic burst_is_write,
  output logic auto_pre_pending,
  // Accepted command, one-cycle pulses; cmd_bank follows the bank pins every cycle
  output logic cmd_valid,
  output spm_pkg::spm_cmd_t cmd_accepted,
  output logic [spm_pkg::SPM_BANK_W-1:0] cmd_bank,
  output logic cmd_rejected,
  // Data enables per byte lane
  output logic [MASK_W-1:0] write_lane_en,
  output logic [MASK_W-1:0] read_lane_oe
);
  spm_state_t state_reg, state_next;
  logic [BANKS-1:0] bank_reg, bank_next;
  logic auto_pre_reg, auto_pre_next;
  logic wr_reg, wr_next;
  logic [SPM_BANK_W-1:0] burst_bank_reg, burst_bank_next;
  logic cmd_valid_reg, cmd_valid_next;
  spm_cmd_t cmd_reg, cmd_next;
  logic [SPM_BANK_W-1:0] cmd_bank_reg;
  logic rej_reg, rej_next;
  logic [MASK_W-1:0] wen_reg, oe_reg;
  logic b_start, b_stop, b_hold, b_busy, b_last;
  logic full_page;

  spm_cmd_if dec_bus ();

  initial begin
    if (BANKS != (1 << SPM_BANK_W)) $error("spm_power_ctrl: BANKS must match bank select width");
    if (MASK_W < 1) $error("spm_power_ctrl: MASK_W must be positive");
  end

  spm_decode u_dec (
    .mclk(mclk),
    .rstn(rstn),
    .chip_select_n(chip_select_n),
    .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n),
    .write_enable_n(write_enable_n),
    .clock_gate_in(clock_gate_in),
    .bank_select(bank_select),
    .precharge_flag_addr(precharge_flag_addr),
    .cmd_o(dec_bus)
  );

  spm_burst #(.BURST_W(SPM_BURST_W)) u_burst (
    .mclk(mclk),
    .rstn(rstn),
    .start(b_start),
    .stop(b_stop),
    .hold(b_hold),
    .length(burst_length),
    .busy(b_busy),
    .last(b_last)
  );

  // Qualified views of the decoded command
  wire gate_was_hi = dec_bus.gate_prev;
  wire gate_is_hi = dec_bus.gate_now;
  wire any_open = |bank_reg;
  wire sel_open = bank_reg[dec_bus.bank];
  wire cmd_live = gate_was_hi && (state_reg == SPM_ST_IDLE || state_reg == SPM_ST_ACTIVE);
  wire is_rdwr = (dec_bus.cmd == SPM_CMD_RD) || (dec_bus.cmd == SPM_CMD_WR);
  assign full_page = (burst_length == SPM_FULL_PAGE);
  // Auto-precharge bursts refuse read, write, precharge and stop
  wire ap_block = auto_pre_reg && b_busy;
  wire is_noop = (dec_bus.cmd == SPM_CMD_NOP) || (dec_bus.cmd == SPM_CMD_DESEL);

  // Legality of the command in the current state
  logic legal;
  always_comb begin
    legal = 1'b0;
    case (dec_bus.cmd)
      SPM_CMD_ACT: legal = !sel_open;
      SPM_CMD_PRE: legal = !ap_block;
      SPM_CMD_RD, SPM_CMD_WR: legal = sel_open && !ap_block && !(dec_bus.pre_flag && full_page);
      SPM_CMD_MRS: legal = !any_open;
      SPM_CMD_BST: legal = b_busy && full_page && !ap_block;
      SPM_CMD_AREF, SPM_CMD_SREF: legal = !any_open;
      default: legal = 1'b1;
    endcase
  end

  wire take = cmd_live && !is_noop && legal;
  assign b_start = take && is_rdwr;
  assign b_stop = take && (dec_bus.cmd == SPM_CMD_BST);
  // Freeze one cycle after gate registered low, release one after high
  assign b_hold = (state_reg == SPM_ST_SUSP);

  // Bank bookkeeping and burst attributes
  always_comb begin
    bank_next = bank_reg;
    auto_pre_next = auto_pre_reg;
    wr_next = wr_reg;
    burst_bank_next = burst_bank_reg;
    if (b_last && auto_pre_reg) begin
      bank_next[burst_bank_reg] = 1'b0;
      auto_pre_next = 1'b0;
    end
    if (take) begin
      case (dec_bus.cmd)
        SPM_CMD_ACT: bank_next[dec_bus.bank] = 1'b1;
        SPM_CMD_PRE: begin
          if (dec_bus.pre_flag) begin
            bank_next = SPM_BANKS_RST;
          end else begin
            bank_next[dec_bus.bank] = 1'b0;
          end
        end
        SPM_CMD_RD, SPM_CMD_WR: begin
          auto_pre_next = dec_bus.pre_flag;
          wr_next = (dec_bus.cmd == SPM_CMD_WR);
          burst_bank_next = dec_bus.bank;
        end
        default: ;
      endcase
    end
  end

  // Power state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SPM_ST_IDLE: begin
        if (take && dec_bus.cmd == SPM_CMD_SREF) begin
          state_next = SPM_ST_SREF;
        end else if (gate_was_hi && !gate_is_hi) begin
          state_next = (any_open || b_busy) ? SPM_ST_SUSP : SPM_ST_PDOWN;
        end else if (|bank_next) begin
          state_next = SPM_ST_ACTIVE;
        end
      end
      SPM_ST_ACTIVE: begin
        if (gate_was_hi && !gate_is_hi) begin
          state_next = SPM_ST_SUSP;
        end else if (!(|bank_next)) begin
          state_next = SPM_ST_IDLE;
        end
      end
      SPM_ST_SREF: begin
        if (gate_is_hi) state_next = SPM_ST_IDLE;
      end
      SPM_ST_PDOWN: begin
        if (gate_is_hi) state_next = SPM_ST_IDLE;
      end
      SPM_ST_SUSP: begin
        if (gate_is_hi) state_next = any_open ? SPM_ST_ACTIVE : SPM_ST_IDLE;
      end
      default: state_next = SPM_ST_IDLE;
    endcase
  end

  // Accepted and rejected command report
  always_comb begin
    cmd_valid_next = take;
    cmd_next = take ? dec_bus.cmd : SPM_CMD_NOP;
    rej_next = cmd_live && !is_noop && !legal;
  end

  // State registers; every input but the asynchronous rstn is sampled on the rising edge only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= SPM_ST_IDLE;
      bank_reg <= SPM_BANKS_RST;
      auto_pre_reg <= 1'b0;
      wr_reg <= 1'b0;
      burst_bank_reg <= '0;
    end else begin
      state_reg <= state_next;
      bank_reg <= bank_next;
      auto_pre_reg <= auto_pre_next;
      wr_reg <= wr_next;
      burst_bank_reg <= burst_bank_next;
    end
  end

  // Report registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_valid_reg <= 1'b0;
      cmd_reg <= SPM_CMD_NOP;
      cmd_bank_reg <= '0;
      rej_reg <= 1'b0;
    end else begin
      cmd_valid_reg <= cmd_valid_next;
      cmd_reg <= cmd_next;
      cmd_bank_reg <= dec_bus.bank;
      rej_reg <= rej_next;
    end
  end

  // Byte lanes: mask low enables data, high blocks it; off outside active
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wen_reg <= '0;
      oe_reg <= '0;
    end else begin
      wen_reg <= (cmd_live && any_open && b_busy && wr_next) ? ~byte_mask : '0;
      oe_reg <= (cmd_live && any_open && b_busy && !wr_next) ? ~byte_mask : '0;
    end
  end

  assign power_state = state_reg;
  assign bank_open = bank_reg;
  // Internal clock stops in self refresh, power down and suspend
  assign internal_clk_en = (state_reg == SPM_ST_IDLE) || (state_reg == SPM_ST_ACTIVE);
  assign burst_busy = b_busy;
  assign burst_is_write = wr_reg;
  assign auto_pre_pending = auto_pre_reg;
  assign cmd_valid = cmd_valid_reg;
  assign cmd_accepted = cmd_reg;
  assign cmd_bank = cmd_bank_reg;
  assign cmd_rejected = rej_reg;
  assign write_lane_en = wen_reg;
  assign read_lane_oe = oe_reg;
endmodule

/* spm_sva.sv */
`timescale 1ns/1ps
module spm_sva
  import spm_pkg::*;
#(
  parameter int BANKS = spm_pkg::SPM_BANKS,
  parameter int MASK_W = spm_pkg::SPM_MASK_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Command pins
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_enable_n,
  input wire logic clock_gate_in,
  input wire logic [spm_pkg::SPM_BANK_W-1:0] bank_select,
  input wire logic [MASK_W-1:0] byte_mask,
  // Status
  input wire spm_pkg::spm_state_t power_state,
  input wire logic [BANKS-1:0] bank_open,
  input wire logic internal_clk_en,
  input wire logic burst_busy,
  input wire logic auto_pre_pending,
  input wire logic cmd_valid,
  input wire spm_pkg::spm_cmd_t cmd_accepted,
  input wire logic cmd_rejected,
  input wire logic [MASK_W-1:0] write_lane_en,
  input wire logic [MASK_W-1:0] read_lane_oe
);
  logic gate_q;
  logic [3:0] pins;
  logic run;

  // Gate level one edge back; starts high like the device
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gate_q <= 1'b1;
    end else begin
      gate_q <= clock_gate_in;
    end
  end

  // Strobes as one code; run means a command may be taken
  assign pins = {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n};
  assign run = gate_q && (power_state == SPM_ST_IDLE || power_state == SPM_ST_ACTIVE);

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_act;
    run && clock_gate_in && pins == 4'h3 && !bank_open[bank_select]
      |=> cmd_valid && cmd_accepted == SPM_CMD_ACT && bank_open[$past(bank_select)];
  endproperty
  a_act: assert property (p_act) else $error("activate not taken");
  property p_desel;
    run && clock_gate_in && chip_select_n && !auto_pre_pending |=> !cmd_rejected && $stable(bank_open);
  endproperty
  a_desel: assert property (p_desel) else $error("deselect had an effect");
  property p_sref_in;
    power_state == SPM_ST_IDLE && gate_q && !clock_gate_in && pins == 4'h1 && !burst_busy
      |=> power_state == SPM_ST_SREF;
  endproperty
  a_sref_in: assert property (p_sref_in) else $error("self refresh not entered");
  property p_sref_stay;
    power_state == SPM_ST_SREF && !clock_gate_in
      |=> power_state == SPM_ST_SREF && !internal_clk_en && !cmd_valid && !cmd_rejected;
  endproperty
  a_sref_stay: assert property (p_sref_stay) else $error("self refresh not held");
  property p_sref_out;
    power_state == SPM_ST_SREF && clock_gate_in |=> power_state == SPM_ST_IDLE;
  endproperty
  a_sref_out: assert property (p_sref_out) else $error("self refresh not left");
  property p_pdown;
    power_state == SPM_ST_IDLE && gate_q && !clock_gate_in && chip_select_n && !burst_busy
      |=> power_state == SPM_ST_PDOWN;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power down not entered");
  property p_susp;
    run && !clock_gate_in && chip_select_n && (bank_open != '0 || burst_busy) |=> power_state == SPM_ST_SUSP;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend not entered");
  property p_susp_stay;
    power_state == SPM_ST_SUSP && !clock_gate_in
      |=> power_state == SPM_ST_SUSP && $stable(bank_open) && $stable(burst_busy) && !cmd_valid && !cmd_rejected;
  endproperty
  a_susp_stay: assert property (p_susp_stay) else $error("suspend not frozen");
  property p_resume;
    power_state == SPM_ST_SUSP && clock_gate_in |=> run || power_state == SPM_ST_IDLE;
  endproperty
  a_resume: assert property (p_resume) else $error("suspend not left");
  property p_bst;
    run && clock_gate_in && pins == 4'h6 && !burst_busy |=> cmd_rejected && !cmd_valid;
  endproperty
  a_bst: assert property (p_bst) else $error("burst stop not refused");
  property p_mask;
    (&byte_mask) [*2] |-> !(|read_lane_oe) && !(|write_lane_en);
  endproperty
  a_mask: assert property (p_mask) else $error("masked lane enabled");

  // Main scenarios reached
  c_sref: cover property (power_state == SPM_ST_SREF);
  c_pdown: cover property (power_state == SPM_ST_PDOWN);
  c_susp: cover property (power_state == SPM_ST_SUSP && burst_busy);
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  import spm_pkg::*;
  logic mclk = 1'b0;
  logic rstn, chip_select_n, row_strobe_n, column_strobe_n, write_enable_n, clock_gate_in, precharge_flag_addr;
  logic [1:0] bank_select, byte_mask, cmd_bank, write_lane_en, read_lane_oe;
  logic [8:0] burst_length;
  logic [3:0] bank_open;
  logic internal_clk_en, burst_busy, burst_is_write, auto_pre_pending, cmd_valid, cmd_rejected;
  spm_state_t power_state;
  spm_cmd_t cmd_accepted;
  int err_total, checks;

  spm_power_ctrl spm_power_ctrl_i (.mclk, .rstn, .chip_select_n, .row_strobe_n, .column_strobe_n,
    .write_enable_n, .clock_gate_in, .bank_select, .precharge_flag_addr, .byte_mask, .burst_length,
    .power_state, .bank_open, .internal_clk_en, .burst_busy, .burst_is_write, .auto_pre_pending,
    .cmd_valid, .cmd_accepted, .cmd_bank, .cmd_rejected, .write_lane_en, .read_lane_oe);
  spm_ctrl_model spm_ctrl_model_i (.mclk, .chip_select_n, .row_strobe_n, .column_strobe_n,
    .write_enable_n, .clock_gate_in, .bank_select, .precharge_flag_addr);

  // 250 MHz clock
  initial begin
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic s(input logic [3:0] c, input logic g, input logic [1:0] b, input logic f);
    spm_ctrl_model_i.send(c, g, b, f);
  endtask

  // Command then a deselect, so the one-cycle answer is on show
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic f);
    s(c, 1'b1, b, f);
    s(4'hf, 1'b1, 2'h0, 1'b0);
  endtask

  // Bounded wait for the burst to run out
  task automatic drain();
    for (int i = 0; i < 40 && burst_busy !== 1'b0; i++) s(4'hf, 1'b1, 2'h0, 1'b0);
    if (burst_busy !== 1'b0) begin
      err_total++;
      stop_test();
    end
  endtask

  task automatic t_act();
    chk(power_state, SPM_ST_IDLE);
    chk(internal_clk_en, 1'b1);
    cmd(4'h3, 2'h1, 1'b0);
    chk(cmd_accepted, SPM_CMD_ACT);
    chk(cmd_bank, 2'h1);
    chk(bank_open, 4'h2);
    cmd(4'h3, 2'h1, 1'b0);
    chk(cmd_rejected, 1'b1);
    cmd(4'hb, 2'h2, 1'b0);
    chk(bank_open, 4'h2);
    cmd(4'h7, 2'h2, 1'b0);
    chk(cmd_rejected, 1'b0);
    $display("test act done");
  endtask

  task automatic t_susp();
    byte_mask = 2'b01;
    burst_length = 9'h008;
    cmd(4'h5, 2'h1, 1'b0);
    chk(cmd_accepted, SPM_CMD_RD);
    s(4'h7, 1'b1, 2'h0, 1'b0);
    chk(read_lane_oe, 2'b10);
    s(4'hf, 1'b0, 2'h0, 1'b0);
    s(4'h2, 1'b0, 2'h1, 1'b1);
    chk(power_state, SPM_ST_SUSP);
    repeat (10) s(4'hf, 1'b0, 2'h0, 1'b0);
    chk(burst_busy, 1'b1);
    chk(bank_open, 4'h2);
    s(4'h7, 1'b1, 2'h0, 1'b0);
    s(4'hf, 1'b1, 2'h0, 1'b0);
    chk(power_state, SPM_ST_ACTIVE);
    chk(burst_busy, 1'b1);
    drain();
    byte_mask = 2'b11;
    $display("test suspend done");
  endtask

  task automatic t_wr_ap();
    byte_mask = 2'b10;
    burst_length = 9'h004;
    cmd(4'h4, 2'h1, 1'b1);
    chk(cmd_accepted, SPM_CMD_WR);
    chk(auto_pre_pending, 1'b1);
    cmd(4'h2, 2'h1, 1'b0);
    chk(cmd_rejected, 1'b1);
    chk(write_lane_en, 2'b01);
    drain();
    byte_mask = 2'b11;
    s(4'hf, 1'b1, 2'h0, 1'b0);
    chk(bank_open, 4'h0);
    $display("test autoprecharge done");
  endtask

  task automatic t_idle();
    cmd(4'h6, 2'h0, 1'b0);
    chk(cmd_rejected, 1'b1);
    cmd(4'h0, 2'h0, 1'b0);
    chk(cmd_accepted, SPM_CMD_MRS);
    cmd(4'h1, 2'h0, 1'b0);
    chk(cmd_accepted, SPM_CMD_AREF);
    s(4'h3, 1'b1, 2'h0, 1'b0);
    cmd(4'h3, 2'h3, 1'b0);
    cmd(4'h2, 2'h0, 1'b0);
    chk(bank_open, 4'h8);
    cmd(4'h2, 2'h1, 1'b1);
    chk(bank_open, 4'h0);
    $display("test idle done");
  endtask

  task automatic t_low_power();
    s(4'h1, 1'b0, 2'h0, 1'b0);
    s(4'h3, 1'b0, 2'h2, 1'b0);
    chk(power_state, SPM_ST_SREF);
    chk(internal_clk_en, 1'b0);
    s(4'hf, 1'b0, 2'h0, 1'b0);
    chk(bank_open, 4'h0);
    spm_ctrl_model_i.wake();
    chk(power_state, SPM_ST_IDLE);
    s(4'hf, 1'b0, 2'h0, 1'b0);
    s(4'h3, 1'b0, 2'h0, 1'b0);
    chk(power_state, SPM_ST_PDOWN);
    s(4'h3, 1'b1, 2'h0, 1'b0);
    s(4'hf, 1'b1, 2'h0, 1'b0);
    chk(bank_open, 4'h0);
    chk(power_state, SPM_ST_IDLE);
    $display("test low power done");
  endtask

  // Reset for four cycles, then the scenarios
  initial begin
    rstn = 1'b0;
    byte_mask = 2'b11;
    burst_length = 9'h004;
    err_total = 0;
    checks = 0;
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    t_act();
    t_susp();
    t_wr_ap();
    t_idle();
    t_low_power();
    stop_test();
  end
endmodule

bind spm_power_ctrl spm_sva #(.BANKS(BANKS), .MASK_W(MASK_W)) spm_sva_i (.mclk, .rstn, .chip_select_n,
  .row_strobe_n, .column_strobe_n, .write_enable_n, .clock_gate_in, .bank_select, .byte_mask,
  .power_state, .bank_open, .internal_clk_en, .burst_busy, .auto_pre_pending, .cmd_valid,
  .cmd_accepted, .cmd_rejected, .write_lane_en, .read_lane_oe);
